// File: hdl/gpc_counter.sv
// Purpose: General-purpose counter/timer with source, gate and one output.
// Assumes: Pins are asynchronous; analog comparison event is on clk_i.
// Notes: Behaviour
// Behaviour
// R1: Source, gate, one output, software registers
// R2: Digital trigger starts or pauses counter
// R3: Analog comparison event usable as trigger
// R4: Start begins pulses; continuous until software stop
// R5: Finite emits count; retrigger restarts generation
// R6: Edge counting holds while paused, resumes
// R7: Continuous pulses stop while paused level
// R8: Falling edge equals inverted rising behaviour
// R9: Gate sampled only at active source edge
// R10: Internal timebase gate uncertainty one period
// R11: Source from pins or internal, edge select
// R12: Each source edge increments or decrements
// R13: Internal source: fast or slow timebase
// R14: Source exportable on pin, floats after reset
// R15: Gate from pins or internal, edge/level
// R16: Gate starts, stops, requests, or saves count
// R17: Gate exportable on pin, floats after reset
// R18: Rollover makes terminal count on output
// R19: Output mode pulse or toggle per event
// R20: Output polarity programmable in both modes
// R21: All pins undriven inputs after reset
// R22: Direction line low down, high up
// R23: Gate save copies count, count unaffected
`timescale 1ns/1ps
module gpc_counter
  import gpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Programmable function pins
  input wire logic [PFI_N-1:0] programmable_function_pin_i,
  output logic [PFI_N-1:0] programmable_function_pin_o,
  output logic [PFI_N-1:0] programmable_function_pin_oe_n_o,
  // Digital lines and direction
  input wire logic count_direction_line_i,
  output logic [DIO_N-1:0] digital_line_oe_n_o,
  // Internal trigger
  input wire logic analog_compare_event_i,
  // Counter outputs
  output logic count_internal_output_o,
  output logic terminal_count_event_o,
  output logic count_gate_request_o,
  output logic count_out_pin_o,
  output logic count_out_pin_oe_n_o
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [PFI_N-1:0] pfi_s1, pfi_s2;
  logic dir_s1, dir_s2;
  logic [TB_W-1:0] fast_cnt, slow_cnt;
  logic src_prev, src_exp, gate_exp, gate_lvl;
  logic [CTRL_W-1:0] ctrl;
  logic [CNT_W-1:0] load_val, pulses, count, saved;
  logic [CNT_W:0] tc_left;
  logic tog, st_tc, st_gate, st_done;
  gpc_state_e state, next_state;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two flops before any logic looks at a pin
  always_ff @(posedge clk_i) begin
    pfi_s1 <= programmable_function_pin_i;
    pfi_s2 <= pfi_s1;
    dir_s1 <= count_direction_line_i;
    dir_s2 <= dir_s1;
  end

  // ----------------------------------------
  // Control field decode
  // ----------------------------------------
  wire [1:0] mode = ctrl[F_MODE +: 2];
  wire [3:0] src_sel = ctrl[F_SRC_SEL +: 4];
  wire [3:0] gate_sel = ctrl[F_GATE_SEL +: 4];
  wire src_fall = ctrl[F_SRC_FALL];
  wire gate_fall = ctrl[F_GATE_FALL];
  wire start_en = ctrl[F_START_EN];
  wire retrig = ctrl[F_RETRIG];
  wire pause_en = ctrl[F_PAUSE_EN];
  wire pause_lvl = ctrl[F_PAUSE_LVL];
  wire out_tog = ctrl[F_OUT_TOG];
  wire out_pol = ctrl[F_OUT_POL];
  wire finite = (mode == MODE_FINITE);
  wire pulse_mode = (mode == MODE_CONT) || finite;

  // ----------------------------------------
  // Internal timebases
  // ----------------------------------------
  // Both timebases are tick enables, so no derived clocks exist
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_cnt <= '0;
      slow_cnt <= '0;
    end else begin
      fast_cnt <= (fast_cnt == FAST_LAST) ? '0 : fast_cnt + 1'b1;
      slow_cnt <= (slow_cnt == SLOW_LAST) ? '0 : slow_cnt + 1'b1;
    end
  end
  wire fast_tick = (fast_cnt == FAST_LAST);
  wire slow_tick = (slow_cnt == SLOW_LAST);

  // ----------------------------------------
  // Source selection and edge detection
  // ----------------------------------------
  // Falling mode just inverts the compare, so all later logic is shared
  wire src_is_pin = (src_sel < 4'(PFI_N)); // R11
  wire src_is_tb = (src_sel == SEL_FAST) || (src_sel == SEL_SLOW); // R13
  wire src_lvl = src_is_pin ? pfi_s2[src_sel] : 1'b0;
  wire ext_edge = src_fall ? (src_prev & ~src_lvl) : (~src_prev & src_lvl); // R8
  wire src_tick = (src_sel == SEL_FAST) ? fast_tick :
                  (src_sel == SEL_SLOW) ? slow_tick :
                  (src_is_pin & ext_edge); // R11

  // ----------------------------------------
  // Gate selection and sampling
  // ----------------------------------------
  // Gate only counts at source edges; asynchronous gates jitter by one period
  wire gate_raw = (gate_sel < 4'(PFI_N)) ? pfi_s2[gate_sel] :
                  (gate_sel == SEL_ANALOG) ? analog_compare_event_i : 1'b0; // R15 R3
  wire gate_now = src_tick ? gate_raw : gate_lvl; // R9 R10
  wire gate_edge = src_tick & ((gate_raw ^ gate_fall) & ~(gate_lvl ^ gate_fall)); // R15

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_prev <= 1'b1; // Pins idle at the pull-up level, so no false edge after reset
      gate_lvl <= 1'b0;
      src_exp <= 1'b0;
      gate_exp <= 1'b0;
    end else begin
      src_prev <= src_lvl;
      gate_lvl <= gate_now; // R9
      src_exp <= src_is_tb ? src_tick : src_lvl;
      gate_exp <= gate_raw;
    end
  end

  // ----------------------------------------
  // Wishbone decode
  // ----------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_wr = bus_req & wb_we_i & wb_ack_o;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire wr_ctrl = bus_wr && (wb_adr_i == REG_CTRL);
  wire wr_load = bus_wr && (wb_adr_i == REG_LOAD);
  wire wr_pulses = bus_wr && (wb_adr_i == REG_PULSES);
  wire wr_status = bus_wr && (wb_adr_i == REG_STATUS);
  wire wr_cmd = bus_wr && (wb_adr_i == REG_CMD) && wb_sel_i[0];
  wire cmd_arm = wr_cmd & wb_dat_i[CMD_ARM]; // R4
  wire cmd_stop = wr_cmd & wb_dat_i[CMD_STOP]; // R4
  wire [31:0] ctrl_m = ({{(32-CTRL_W){1'b0}}, ctrl} & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] load_m = ({{(32-CNT_W){1'b0}}, load_val} & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] puls_m = ({{(32-CNT_W){1'b0}}, pulses} & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] clr_m = wr_status ? (wb_dat_i & wmask) : 32'h0000_0000;

  // ----------------------------------------
  // Sequencing decode
  // ----------------------------------------
  // Pausing applies to edge counting and continuous generation only
  wire paused = pause_en & ~finite & (gate_now == pause_lvl); // R6 R7
  wire restart = (state == S_RUN) & gate_edge & start_en & retrig & finite; // R5
  wire load_now = ((state == S_IDLE) & cmd_arm & ~start_en) |
                  ((state == S_ARMED) & gate_edge & ~cmd_stop) | restart; // R2 R4
  wire run_tick = (state == S_RUN) & src_tick & ~paused & ~load_now; // R12
  wire count_up = pulse_mode ? 1'b0 : (ctrl[F_DIR_EXT] ? dir_s2 : ctrl[F_DIR_UP]); // R22
  wire tc = run_tick & (count_up ? (count == CNT_MAX) : (count == '0)); // R18
  wire done = tc & finite & (tc_left == TCL_ONE); // R5
  wire gate_stop = (state == S_RUN) & gate_edge & ctrl[F_STOP_EN]; // R16
  wire next_tog = load_now ? 1'b0 : (tc ? ~tog : tog); // R19
  wire [CNT_W-1:0] step = count_up ? count + 1'b1 : count - 1'b1; // R12

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: begin
        if (cmd_arm) begin
          next_state = start_en ? S_ARMED : S_RUN; // R4
        end
      end
      S_ARMED: begin
        if (cmd_stop) begin
          next_state = S_IDLE;
        end else if (gate_edge) begin
          next_state = S_RUN; // R2
        end
      end
      S_RUN: begin
        if (cmd_stop || gate_stop) begin
          next_state = S_IDLE; // R4 R16
        end else if (done && !restart) begin
          next_state = (retrig && start_en) ? S_ARMED : S_IDLE; // R5
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= '0;
      load_val <= '0;
      pulses <= '0;
    end else begin
      if (wr_ctrl) ctrl <= ctrl_m[CTRL_W-1:0]; // R1
      if (wr_load) load_val <= load_m[CNT_W-1:0];
      if (wr_pulses) pulses <= puls_m[CNT_W-1:0];
    end
  end

  // Sticky flags: a new event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_tc <= 1'b0;
      st_gate <= 1'b0;
      st_done <= 1'b0;
    end else begin
      st_tc <= tc | (st_tc & ~clr_m[ST_TC]);
      st_gate <= gate_edge | (st_gate & ~clr_m[ST_GATE]);
      st_done <= done | (st_done & ~clr_m[ST_DONE]);
    end
  end

  // ----------------------------------------
  // Counter core
  // ----------------------------------------
  // Pulse modes count down and reload; edge counting wraps freely
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
      tc_left <= '0;
      saved <= '0;
    end else begin
      if (load_now) begin
        count <= load_val; // R4 R5
        tc_left <= {pulses, 1'b0}; // R5
      end else if (run_tick) begin
        count <= (tc && pulse_mode) ? load_val : step; // R12 R22
        if (tc) tc_left <= tc_left - TCL_ONE;
      end
      if (gate_edge && ctrl[F_SAVE_EN]) saved <= count; // R16 R23
    end
  end

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  // Pulse width is one clock; toggle gives a square wave per two events
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tog <= 1'b0;
      count_internal_output_o <= 1'b0;
      terminal_count_event_o <= 1'b0;
      count_gate_request_o <= 1'b0;
      count_out_pin_o <= 1'b0;
    end else begin
      tog <= next_tog;
      count_internal_output_o <= out_pol ^ (out_tog ? next_tog : tc); // R18 R19 R20
      terminal_count_event_o <= tc; // R18
      count_gate_request_o <= gate_edge & ctrl[F_REQ_EN]; // R16
      count_out_pin_o <= out_pol ^ (out_tog ? next_tog : tc);
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Pin enables come from the control register, which clears on reset; digital lines are never driven
  genvar g;
  generate
    for (g = 0; g < PFI_N; g++) begin : g_pin
      wire is_src = (g == SRC_EXPORT_PIN);
      wire is_gate = (g == GATE_EXPORT_PIN);
      assign programmable_function_pin_o[g] = is_src ? src_exp : (is_gate ? gate_exp : 1'b0);
      assign programmable_function_pin_oe_n_o[g] =
        ~((is_src & ctrl[F_EXP_SRC]) | (is_gate & ctrl[F_EXP_GATE])); // R14 R17 R21
    end
  endgenerate
  assign count_out_pin_oe_n_o = ~ctrl[F_EXP_OUT]; // R21
  assign digital_line_oe_n_o = {DIO_N{1'b1}}; // R21

  // ----------------------------------------
  // Register read and acknowledge
  // ----------------------------------------
  wire [31:0] status_w = {25'h0, st_done, st_gate, st_tc, count_internal_output_o,
                          paused, state == S_ARMED, state == S_RUN};
  wire [31:0] rdata =
    (wb_adr_i == REG_CTRL) ? {{(32-CTRL_W){1'b0}}, ctrl} :
    (wb_adr_i == REG_LOAD) ? {{(32-CNT_W){1'b0}}, load_val} :
    (wb_adr_i == REG_PULSES) ? {{(32-CNT_W){1'b0}}, pulses} :
    (wb_adr_i == REG_COUNT) ? {{(32-CNT_W){1'b0}}, count} :
    (wb_adr_i == REG_SAVE) ? {{(32-CNT_W){1'b0}}, saved} :
    (wb_adr_i == REG_STATUS) ? status_w : 32'h0000_0000;

  // Answer every address after one wait cycle; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o) wb_dat_o <= rdata;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_new_req;
    bus_req && !wb_ack_o;
  endsequence
  sequence s_one_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_bus_ack_once: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    s_new_req |=> s_one_ack) else $error("ack not a single cycle");
  a_pins_float: assert property (@(posedge clk_i) // R21
    rst_i |=> (&programmable_function_pin_oe_n_o) && count_out_pin_oe_n_o)
    else $error("pin driven after reset");
  a_start_trig: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    state == S_ARMED && gate_edge && !cmd_stop |=> state == S_RUN && count == $past(load_val))
    else $error("start trigger not taken");
  a_pause_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    state == S_RUN && paused && !load_now |=> $stable(count))
    else $error("count moved while paused");
  a_dir_down: assert property (@(posedge clk_i) disable iff (rst_i) // R22
    run_tick && mode == MODE_EDGE && ctrl[F_DIR_EXT] && !dir_s2
    |=> count == $past(count) - 1'b1) else $error("external direction ignored");
  a_save_copy: assert property (@(posedge clk_i) disable iff (rst_i) // R23
    gate_edge && ctrl[F_SAVE_EN] && !load_now && !tc
    |=> saved == $past(count) && count == ($past(run_tick) ? $past(step) : $past(count)))
    else $error("save wrong");
  a_gate_sample: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    !src_tick |=> $stable(gate_lvl)) else $error("gate sampled off edge");
  a_toggle_tc: assert property (@(posedge clk_i) disable iff (rst_i) // R19
    tc && out_tog && !wr_ctrl |=> count_internal_output_o != $past(count_internal_output_o))
    else $error("no toggle on terminal count");
  a_pulse_pol: assert property (@(posedge clk_i) disable iff (rst_i) // R20
    tc && !out_tog && !wr_ctrl |=> count_internal_output_o == !out_pol ##1
    (count_internal_output_o == out_pol) || wr_ctrl) else $error("pulse polarity wrong");
  a_finite_end: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    done && !restart && !cmd_stop |=> state != S_RUN) else $error("finite run kept going");
endmodule : gpc_counter

// File: shared/gpc_pkg.sv
// Purpose: Constants, register map and types for the general-purpose counter.
// Assumes: 40 MHz system clock, classic Wishbone with 32-bit data.
// Notes: Timebase dividers derive from the clock rate.
package gpc_pkg;
  // ----------------------------------------
  // Clock and timebases
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned FAST_TB_HZ = 20_000_000;
  localparam int unsigned SLOW_TB_HZ = 100_000;
  localparam int TB_W = 9;
  localparam logic [TB_W-1:0] FAST_LAST = TB_W'(CLK_HZ / FAST_TB_HZ - 1);
  localparam logic [TB_W-1:0] SLOW_LAST = TB_W'(CLK_HZ / SLOW_TB_HZ - 1);
  // ----------------------------------------
  // Widths and pins
  // ----------------------------------------
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam logic [CNT_W:0] TCL_ONE = {{CNT_W{1'b0}}, 1'b1};
  localparam int PFI_N = 10;
  localparam int DIO_N = 8;
  localparam int SRC_EXPORT_PIN = 8;
  localparam int GATE_EXPORT_PIN = 9;
  // Selector codes: 0..9 pick a function pin
  localparam logic [3:0] SEL_FAST = 4'ha;
  localparam logic [3:0] SEL_SLOW = 4'hb;
  localparam logic [3:0] SEL_ANALOG = 4'ha;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_LOAD = 5'h04;
  localparam logic [4:0] REG_PULSES = 5'h08;
  localparam logic [4:0] REG_COUNT = 5'h0c;
  localparam logic [4:0] REG_SAVE = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  localparam logic [4:0] REG_CMD = 5'h18;
  // Control fields
  localparam int CTRL_W = 26;
  localparam int F_MODE = 0;
  localparam int F_SRC_SEL = 2;
  localparam int F_SRC_FALL = 6;
  localparam int F_GATE_SEL = 7;
  localparam int F_START_EN = 11;
  localparam int F_RETRIG = 12;
  localparam int F_PAUSE_EN = 13;
  localparam int F_PAUSE_LVL = 14;
  localparam int F_SAVE_EN = 15;
  localparam int F_STOP_EN = 16;
  localparam int F_REQ_EN = 17;
  localparam int F_OUT_TOG = 18;
  localparam int F_OUT_POL = 19;
  localparam int F_DIR_EXT = 20;
  localparam int F_DIR_UP = 21;
  localparam int F_EXP_SRC = 22;
  localparam int F_EXP_GATE = 23;
  localparam int F_EXP_OUT = 24;
  localparam int F_GATE_FALL = 25;
  // Command and status bits
  localparam int CMD_ARM = 0;
  localparam int CMD_STOP = 1;
  localparam int ST_TC = 4;
  localparam int ST_GATE = 5;
  localparam int ST_DONE = 6;
  typedef enum logic [1:0] {
    MODE_EDGE = 2'b00, MODE_CONT = 2'b01, MODE_FINITE = 2'b10
  } gpc_mode_e;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_ARMED = 2'b01, S_RUN = 2'b10
  } gpc_state_e;
endpackage : gpc_pkg

// File: testbench/gpc_pin_model.sv
// Purpose: Far-side model of the timing signals on the function pins.
// Assumes: Unused pins rest at the weak pull-up level.
// Notes: Pin 0 carries source pulses (3 clocks low, 3 high), pin 1 the gate.
`timescale 1ns/1ps
module gpc_pin_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic go_i,
  input wire logic [7:0] n_i,
  input wire logic gate_i,
  // Pin side
  output logic [9:0] pin_o,
  output logic busy_o
);
  logic [7:0] left;
  logic [2:0] ph;
  // Whole low-high periods; spacing keeps edges well past the synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left <= 8'h00;
      ph <= 3'h0;
    end else if (left == 8'h00) begin
      if (go_i) begin
        left <= n_i;
      end
      ph <= 3'h0;
    end else begin
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      if (ph == 3'h5) begin
        left <= left - 8'h01;
      end
    end
  end
  assign busy_o = (left != 8'h00);
  // Source stands high between bursts, as the pull-up leaves it
  assign pin_o = {8'hff, gate_i, (left == 8'h00) || (ph > 3'h2)};
endmodule : gpc_pin_model

// File: testbench/test_general_purpose_counter.sv
// Purpose: Self-checking bench for the counter through its bus and pins.
// Assumes: Arming without the start trigger loads LOAD into the count in every mode.
// Notes: Timebase tests accept one tick of phase uncertainty.
`timescale 1ns/1ps
module test_general_purpose_counter
  import gpc_pkg::*;
;
  localparam logic [31:0] GP = 32'h1 << F_GATE_SEL;
  localparam logic [31:0] FAST = 32'(SEL_FAST) << F_SRC_SEL;
  localparam logic [31:0] CONT = 32'(MODE_CONT) << F_MODE;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, dir = 1'b0, analog = 1'b0, gate = 1'b0, go = 1'b0, busy;
  logic [7:0] n = 8'h00;
  logic [9:0] pin_i, pin_o, pin_oe_n, model_pin;
  logic [7:0] dl_oe_n;
  logic out, tc, req, out_pin, out_pin_oe_n, out_q = 1'b0;
  int miscompares = 0, checks = 0, cycles = 0;
  int n_tc = 0, n_rise = 0, n_fall = 0, n_req = 0;
  always #12.5 clk_i = ~clk_i;
  // Driven pins show the design, released ones the far side
  assign pin_i = (pin_oe_n & model_pin) | (~pin_oe_n & pin_o);
  gpc_counter gpc_counter_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .programmable_function_pin_i(pin_i), .programmable_function_pin_o(pin_o),
    .programmable_function_pin_oe_n_o(pin_oe_n), .count_direction_line_i(dir),
    .digital_line_oe_n_o(dl_oe_n), .analog_compare_event_i(analog),
    .count_internal_output_o(out), .terminal_count_event_o(tc),
    .count_gate_request_o(req), .count_out_pin_o(out_pin),
    .count_out_pin_oe_n_o(out_pin_oe_n));
  gpc_pin_model gpc_pin_model_inst (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .n_i(n),
    .gate_i(gate), .pin_o(model_pin), .busy_o(busy));
  // ----------------------------------------
  // Event counters and hang guard
  // ----------------------------------------
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    out_q <= out;
    if (tc === 1'b1) n_tc <= n_tc + 1;
    if (req === 1'b1) n_req <= n_req + 1;
    if (out === 1'b1 && out_q === 1'b0) n_rise <= n_rise + 1;
    if (out === 1'b0 && out_q === 1'b1) n_fall <= n_fall + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Compare, bus and pin tasks
  // ----------------------------------------
  task automatic chk32(input logic [31:0] a, input logic [31:0] e);
    checks = checks + 1;
    if (a !== e) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: got %h expected %h", $time, a, e);
    end
  endtask : chk32
  task automatic chk1(input logic a, input logic e);
    chk32({31'h0, a}, {31'h0, e});
  endtask : chk1
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic xfer(input logic we, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk32(q, e);
  endtask : rd
  task automatic burst(input logic [7:0] k);
    @(posedge clk_i);
    go <= 1'b1;
    n <= k;
    @(posedge clk_i);
    go <= 1'b0;
    do @(posedge clk_i); while (busy);
    repeat (6) @(posedge clk_i);
  endtask : burst
  // Stop, configure, load and arm; counters cleared once armed
  task automatic run(input logic [31:0] c, input logic [31:0] ld);
    wr(REG_CMD, 32'h2);
    wr(REG_CTRL, c);
    wr(REG_LOAD, ld);
    wr(REG_CMD, 32'h1);
    n_tc <= 0;
    n_rise <= 0;
    n_fall <= 0;
    n_req <= 0;
  endtask : run
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk32({22'h0, pin_oe_n}, 32'h3ff);
    chk32({24'h0, dl_oe_n}, 32'hff);
    chk1(out_pin_oe_n, 1'b1);
    chk1(out, 1'b0);
    rd(REG_CTRL, 32'h0);
    rd(5'h1c, 32'h0);
    // Exports drive pins 8, 9 and the output pin; gate shows on pin 9
    wr(REG_CTRL, GP | (32'h7 << F_EXP_SRC));
    gate <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk32({22'h0, pin_oe_n}, 32'h0ff);
    chk1(out_pin_oe_n, 1'b0);
    chk1(pin_o[9], 1'b1);
    chk1(pin_o[8], 1'b1);
    rd(REG_CTRL, GP | (32'h7 << F_EXP_SRC));
    gate <= 1'b0;
    // Edge counting from a pin, both edge senses and both directions
    run(GP | (32'h1 << F_DIR_UP), 32'h10);
    burst(8'd5);
    rd(REG_COUNT, 32'h15);
    run(GP | (32'h1 << F_SRC_FALL) | (32'h1 << F_DIR_UP), 32'h0);
    burst(8'd4);
    rd(REG_COUNT, 32'h4);
    run(GP | (32'h1 << F_DIR_EXT), 32'h2);
    burst(8'd3);
    rd(REG_COUNT, 32'hffffff);
    dir <= 1'b1;
    burst(8'd2);
    rd(REG_COUNT, 32'h1);
    // Pause on low gate holds the count, high gate resumes
    run(GP | (32'h1 << F_PAUSE_EN) | (32'h1 << F_DIR_UP), 32'h0);
    burst(8'd4);
    rd(REG_COUNT, 32'h0);
    gate <= 1'b1;
    burst(8'd3);
    rd(REG_COUNT, 32'h3);
    // Gate edge saves the count and requests, count runs on
    gate <= 1'b0;
    run(GP | (32'h1 << F_SAVE_EN) | (32'h1 << F_REQ_EN) | (32'h1 << F_DIR_UP), 32'h0);
    burst(8'd4);
    gate <= 1'b1;
    burst(8'd4);
    rd(REG_COUNT, 32'h8);
    xfer(1'b0, REG_SAVE, 32'h0);
    chk1(q == 32'h4 || q == 32'h5, 1'b1);
    chk32(32'(n_req), 32'h1);
    // Slow timebase: one tick per 400 clocks
    run((32'(SEL_SLOW) << F_SRC_SEL) | (32'h1 << F_DIR_UP), 32'h0);
    repeat (1000) @(posedge clk_i);
    xfer(1'b0, REG_COUNT, 32'h0);
    chk1(q == 32'h2 || q == 32'h3, 1'b1);
    // Finite toggle run started and restarted by the analog event
    wr(REG_PULSES, 32'h2);
    run((32'(MODE_FINITE) << F_MODE) | FAST | (32'(SEL_ANALOG) << F_GATE_SEL)
      | (32'h3 << F_START_EN) | (32'h1 << F_OUT_TOG), 32'h1);
    repeat (20) @(posedge clk_i);
    chk32(32'(n_tc), 32'h0);
    for (int k = 0; k < 2; k++) begin
      n_tc <= 0;
      n_rise <= 0;
      analog <= 1'b1;
      repeat (4) @(posedge clk_i);
      analog <= 1'b0;
      repeat (60) @(posedge clk_i);
      chk32(32'(n_tc), 32'h4);
      chk32(32'(n_rise), 32'h2);
    end
    xfer(1'b0, REG_STATUS, 32'h0);
    chk1(q[ST_DONE], 1'b1);
    // Inverted pulse output in continuous mode until software stop
    run(CONT | FAST | (32'h1 << F_OUT_POL), 32'h3);
    repeat (4) @(posedge clk_i);
    chk1(out, 1'b1);
    chk1(out_pin, 1'b1);
    repeat (80) @(posedge clk_i);
    wr(REG_CMD, 32'h2);
    chk1(n_tc >= 9 && n_tc <= 11, 1'b1);
    chk32(32'(n_fall), 32'(n_tc));
    // A count at the stop edge still shows one clock later
    repeat (2) @(posedge clk_i);
    n_tc <= 0;
    repeat (40) @(posedge clk_i);
    chk32(32'(n_tc), 32'h0);
    // Continuous generation held by the pause level
    gate <= 1'b0;
    run(CONT | FAST | GP | (32'h1 << F_PAUSE_EN), 32'h3);
    repeat (40) @(posedge clk_i);
    chk32(32'(n_tc), 32'h0);
    gate <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk1(n_tc >= 3 && n_tc <= 6, 1'b1);
    report_and_stop();
  end
endmodule : test_general_purpose_counter
